// ===== verilog/fsc_pkg.sv
/*
   Shared constants, types and helpers of the FSK transmitter serial command block.
   Assumes a 100 MHz system clock; all times are turned into cycles of that clock here.
*/
package fsc_pkg;
   localparam int CLK_HZ          = 100_000_000;
   localparam int POR_TIMEOUT_MS  = 50;
   localparam int POR_CYCLES      = POR_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int OSC_START_MS    = 5;
   localparam int OSC_CYCLES      = OSC_START_MS * (CLK_HZ / 1000);
   localparam int PLL_START_US    = 250;
   localparam int PLL_CYCLES      = PLL_START_US * (CLK_HZ / 1_000_000);

   localparam logic [15:0] CFG_RESET   = 16'h8080;
   localparam logic [15:0] PM_RESET    = 16'hC000;
   localparam logic [7:0]  SLEEP_RESET = 8'h00;

   localparam logic [2:0] CMD_CFG_CODE   = 3'h4;
   localparam logic [7:0] CMD_PM_CODE    = 8'hC0;
   localparam logic [7:0] CMD_SLEEP_CODE = 8'hC4;
   localparam logic [7:0] CMD_TX_CODE    = 8'hC6;
   localparam logic [4:0] BYTE_BITS      = 5'h08;
   localparam logic [4:0] WORD_BITS      = 5'h10;
   localparam logic [4:0] COUNT_MAX      = 5'h1F;

   localparam int BAND_HI   = 12;
   localparam int BAND_LO   = 11;
   localparam int CLKDIV_HI = 10;
   localparam int CLKDIV_LO = 8;
   localparam int LOAD_HI   = 7;
   localparam int LOAD_LO   = 4;
   localparam int DEV_SIGN  = 3;
   localparam int DEV_HI    = 2;
   localparam int DEV_LO    = 0;

   localparam int PM_AUTO_OSC = 7;
   localparam int PM_AUTO_AMP = 6;
   localparam int PM_OSC      = 5;
   localparam int PM_SYNTH    = 4;
   localparam int PM_AMP      = 3;
   localparam int PM_BATT     = 2;
   localparam int PM_WAKE     = 1;
   localparam int PM_CLKDIS   = 0;

   typedef enum logic [2:0] {
      FSC_IDLE,
      FSC_OSC_WAIT,
      FSC_SYNTH_WAIT,
      FSC_RUN,
      FSC_TAIL
   } fsc_seq_e;

   // half period of the host clock output in system cycles, per divider code
   function automatic logic [5:0] fsc_half_period(input logic [2:0] code);
      case (code)
         3'h0:    fsc_half_period = 6'h32;
         3'h1:    fsc_half_period = 6'h28;
         3'h2:    fsc_half_period = 6'h1E;
         3'h3:    fsc_half_period = 6'h19;
         3'h4:    fsc_half_period = 6'h14;
         3'h5:    fsc_half_period = 6'h0F;
         3'h6:    fsc_half_period = 6'h0A;
         default: fsc_half_period = 6'h05;
      endcase
   endfunction
endpackage

// ===== verilog/fsc_shift_if.sv
/*
   Carrier between the serial shifter and the command decoder.
   Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface fsc_shift_if;
   logic [15:0] word;
   logic [4:0]  count;
   logic        byte_done;
   logic        frame_active;

   modport shifter (output word, output count, output byte_done, output frame_active);
   modport decoder (input word, input count, input byte_done, input frame_active);
endinterface

// ===== verilog/fsc_serial_shifter.sv
/*
   Serial shifter: synchronises the select, clock and data pins and shifts bits in MSB first.
   Assumes the link clock is much slower than the system clock (at least 3 samples per phase).
*/
`timescale 1ns/1ps
module fsc_serial_shifter (
   input  wire logic            sys_clk_in,
   input  wire logic            srst_in,
   input  wire logic            select_low_in,
   input  wire logic            serial_clk_in,
   input  wire logic            serial_data_in,
   fsc_shift_if.shifter         lnk
);
   typedef struct packed {
      logic        sel_s1;
      logic        sel_s2;
      logic        sck_s1;
      logic        sck_s2;
      logic        sck_d;
      logic        sdi_s1;
      logic        sdi_s2;
      logic [15:0] word;
      logic [4:0]  count;
      logic        byte_done;
   } fsc_shift_s;

   localparam fsc_shift_s SHIFT_RESET = '{sel_s1: 1'b1, sel_s2: 1'b1, default: '0};

   fsc_shift_s r_reg;
   fsc_shift_s r_next;

   always_comb begin
      r_next = r_reg;
      r_next.byte_done = 1'b0;
      r_next.sel_s1 = select_low_in;
      r_next.sel_s2 = r_reg.sel_s1;
      r_next.sck_s1 = serial_clk_in;
      r_next.sck_s2 = r_reg.sck_s1;
      r_next.sck_d = r_reg.sck_s2;
      r_next.sdi_s1 = serial_data_in;
      r_next.sdi_s2 = r_reg.sdi_s1;
      if (r_reg.sel_s2) begin
         r_next.word = '0; // RULE2
         r_next.count = '0; // RULE2
      end else if (r_reg.sck_s2 && !r_reg.sck_d) begin
         r_next.word = {r_reg.word[14:0], r_reg.sdi_s2}; // RULE1 RULE4
         if (r_reg.count != fsc_pkg::COUNT_MAX) begin
            r_next.count = r_reg.count + 5'h01;
         end
         r_next.byte_done = (r_next.count[2:0] == 3'h0) && (r_reg.count != fsc_pkg::COUNT_MAX);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         r_reg <= SHIFT_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign lnk.word = r_reg.word;
   assign lnk.count = r_reg.count;
   assign lnk.byte_done = r_reg.byte_done;
   assign lnk.frame_active = !r_reg.sel_s2;

   shift_in_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE1
      (r_reg.sck_s2 && !r_reg.sck_d && !r_reg.sel_s2)
      |=> (r_reg.word[0] == $past(r_reg.sdi_s2) && r_reg.word[15:1] == $past(r_reg.word[14:0])))
      else $error("serial bit not shifted in msb first");
   sel_clear_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE2
      r_reg.sel_s2 |=> (r_reg.count == 5'h00 && !r_reg.byte_done))
      else $error("shift logic not cleared while select high");
endmodule

// ===== verilog/fsc_cmd_top.sv
/*
   Serial command port with configuration and power management registers, automatic
   oscillator/synthesizer/amplifier sequencing, event oscillator hold and host clock output.
   Assumes pins come from outside the system clock domain; event inputs are on the system clock.
*/
`timescale 1ns/1ps
// Functional notes
// RULE1: while select is low, data is taken on each rising serial clock edge.
// RULE2: select high clears the shift logic so each low period starts fresh.
// RULE3: the host sends only whole bytes per select-low period.
// RULE4: commands are a code plus parameters, sent most significant bit first.
// RULE5: reset loads defaults into configuration and power registers.
// RULE6: commands arriving during the power-on timeout are ignored.
// RULE7: band field in bits 12:11 selects 433, 868 or 915 MHz; reset 8080h.
// RULE8: load field bits 7:4 selects 8.5 to 16.0 pF in half pF steps.
// RULE9: clock field bits 10:8 selects host clock from 1 to 10 MHz.
// RULE10: deviation is (M+1) times 30 kHz; direction is sign xor modulation input.
// RULE11: the host uses deviation values 0 through 6 only.
// RULE12: power bits 5..1 enable oscillator, synthesizer, amplifier, battery detector, wake timer.
// RULE13: power bit 0 disables the host clock output buffer.
// RULE14: data transmit command can switch oscillator, synthesizer, amplifier automatically.
// RULE15: with bit 7 set, transmit starts oscillator, then synthesizer once reference stable.
// RULE16: with bit 6 also set, amplifier turns on after a further lock delay.
// RULE17: host leaves direct enables zero to get automatic control.
// RULE18: host sets oscillator enable for proper control, may clear it afterwards.
// RULE19: host may send sleep to mark end of transmission.
// RULE20: events run the oscillator; with clock output enabled it stays until sleep.
// RULE21: sleep resets the event controller.
// RULE22: sleep stops automatic amplifier and synthesizer; oscillator after S host clocks.
// RULE23: a command takes effect only when complete; cut words are discarded.
module fsc_cmd_top #(
   parameter int POR_LEN = fsc_pkg::POR_CYCLES,
   parameter int OSC_LEN = fsc_pkg::OSC_CYCLES,
   parameter int PLL_LEN = fsc_pkg::PLL_CYCLES
) (
   input  wire logic       sys_clk_in,
   input  wire logic       srst_in,
   input  wire logic       select_low_in,
   input  wire logic       serial_clk_in,
   input  wire logic       serial_data_in,
   input  wire logic       fsk_data_in,
   input  wire logic       battery_event_in,
   input  wire logic       wake_event_in,
   output logic [1:0]      band_sel_out,
   output logic [3:0]      load_cap_code_out,
   output logic [2:0]      clkout_div_code_out,
   output logic [3:0]      deviation_step_out,
   output logic            deviation_dir_out,
   output logic            osc_on_out,
   output logic            synth_on_out,
   output logic            amp_on_out,
   output logic            battery_detect_on_out,
   output logic            wake_timer_on_out,
   output logic            clkout_out,
   output logic            clkout_en_out,
   output logic            por_busy_out
);
   typedef struct packed {
      logic [15:0]        cfg;
      logic [15:0]        pm;
      logic [23:0]        por_cnt;
      logic               por_busy;
      logic               tx_frame;
      fsc_pkg::fsc_seq_e  seq;
      logic [23:0]        wait_cnt;
      logic [7:0]         tail_left;
      logic               hold;
      logic               fsk_s1;
      logic               fsk_s2;
      logic [5:0]         div_cnt;
      logic               clk_q;
      logic               period_tick;
      logic               applied;
   } fsc_top_s;

   localparam fsc_top_s TOP_RESET = '{
      cfg: fsc_pkg::CFG_RESET, pm: fsc_pkg::PM_RESET, por_busy: 1'b1, hold: 1'b1,
      seq: fsc_pkg::FSC_IDLE, tail_left: fsc_pkg::SLEEP_RESET, default: '0};

   fsc_top_s r_reg;
   fsc_top_s r_next;
   fsc_shift_if lnk ();

   logic cmd_ok;
   logic word_done;
   logic tx_hit;
   logic sleep_hit;
   logic auto_osc;
   logic auto_amp;

   fsc_serial_shifter u_shift (
      .sys_clk_in     (sys_clk_in),
      .srst_in        (srst_in),
      .select_low_in  (select_low_in),
      .serial_clk_in  (serial_clk_in),
      .serial_data_in (serial_data_in),
      .lnk            (lnk)
   );

   assign auto_osc = r_reg.pm[fsc_pkg::PM_AUTO_OSC];
   assign auto_amp = r_reg.pm[fsc_pkg::PM_AUTO_AMP];

   // nothing from the link is honoured until the power-on timeout ends or inside a data stream
   assign cmd_ok = lnk.byte_done && !r_reg.por_busy && !r_reg.tx_frame; // RULE6
   assign word_done = cmd_ok && (lnk.count == fsc_pkg::WORD_BITS); // RULE23
   assign tx_hit = cmd_ok && (lnk.count == fsc_pkg::BYTE_BITS) && (lnk.word[7:0] == fsc_pkg::CMD_TX_CODE);
   assign sleep_hit = word_done && (lnk.word[15:8] == fsc_pkg::CMD_SLEEP_CODE);

   always_comb begin
      r_next = r_reg;
      r_next.applied = 1'b0;
      r_next.period_tick = 1'b0;
      r_next.fsk_s1 = fsk_data_in;
      r_next.fsk_s2 = r_reg.fsk_s1;

      // power-on timeout; the count stops once it has run out
      if (r_reg.por_busy) begin
         if (r_reg.por_cnt == 24'(POR_LEN - 1)) begin
            r_next.por_busy = 1'b0; // RULE6
         end else begin
            r_next.por_cnt = r_reg.por_cnt + 24'h000001;
         end
      end

      // host clock divider runs always so the sleep tail is timed even with the buffer off
      if (r_reg.div_cnt >= fsc_pkg::fsc_half_period(r_reg.cfg[fsc_pkg::CLKDIV_HI:fsc_pkg::CLKDIV_LO]) - 6'h01) begin
         r_next.div_cnt = '0; // RULE9
         r_next.clk_q = !r_reg.clk_q;
         r_next.period_tick = r_reg.clk_q;
      end else begin
         r_next.div_cnt = r_reg.div_cnt + 6'h01;
      end

      if (tx_hit) begin
         r_next.tx_frame = 1'b1; // RULE14
      end
      if (!lnk.frame_active) begin
         r_next.tx_frame = 1'b0;
      end
      // registers change only on the 16th bit, so a cut word leaves no trace
      if (word_done) begin
         if (lnk.word[15:13] == fsc_pkg::CMD_CFG_CODE) begin
            r_next.cfg = lnk.word; // RULE7 RULE8 RULE10
            r_next.applied = 1'b1;
         end else if (lnk.word[15:8] == fsc_pkg::CMD_PM_CODE) begin
            r_next.pm = lnk.word; // RULE12 RULE13
            r_next.applied = 1'b1;
         end else if (sleep_hit) begin
            r_next.applied = 1'b1;
         end
      end

      // fixed wait counts stand in for oscillator and lock detectors not modelled here
      case (r_reg.seq)
         fsc_pkg::FSC_OSC_WAIT: begin
            if (r_reg.wait_cnt == 24'(OSC_LEN - 1)) begin
               r_next.seq = fsc_pkg::FSC_SYNTH_WAIT; // RULE15
               r_next.wait_cnt = '0;
            end else begin
               r_next.wait_cnt = r_reg.wait_cnt + 24'h000001;
            end
         end

         fsc_pkg::FSC_SYNTH_WAIT: begin
            if (r_reg.wait_cnt == 24'(PLL_LEN - 1)) begin
               r_next.seq = fsc_pkg::FSC_RUN; // RULE16
               r_next.wait_cnt = '0;
            end else begin
               r_next.wait_cnt = r_reg.wait_cnt + 24'h000001;
            end
         end

         fsc_pkg::FSC_TAIL: begin
            if (r_reg.tail_left == 8'h00) begin
               r_next.seq = fsc_pkg::FSC_IDLE; // RULE22
            end else if (r_reg.period_tick) begin
               r_next.tail_left = r_reg.tail_left - 8'h01;
            end
         end

         default: begin
         end
      endcase

      // a running oscillator needs no startup wait
      if (tx_hit && auto_osc && (r_reg.seq == fsc_pkg::FSC_IDLE || r_reg.seq == fsc_pkg::FSC_TAIL)) begin
         r_next.seq = osc_on_out ? fsc_pkg::FSC_SYNTH_WAIT : fsc_pkg::FSC_OSC_WAIT; // RULE15
         r_next.wait_cnt = '0;
      end

      // a direct oscillator enable skips the tail; the host then stops it itself
      if (sleep_hit) begin
         r_next.hold = 1'b0; // RULE21
         if (r_reg.seq != fsc_pkg::FSC_IDLE) begin
            r_next.seq = r_reg.pm[fsc_pkg::PM_OSC] ? fsc_pkg::FSC_IDLE : fsc_pkg::FSC_TAIL; // RULE22
            r_next.tail_left = lnk.word[7:0];
            r_next.wait_cnt = '0;
         end
      end else if (r_reg.pm[fsc_pkg::PM_CLKDIS]) begin
         r_next.hold = 1'b0; // RULE20
      end
      // an event in the same cycle as a sleep still keeps the oscillator
      if (battery_event_in || wake_event_in) begin
         r_next.hold = 1'b1; // RULE20
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         r_reg <= TOP_RESET; // RULE5
      end else begin
         r_reg <= r_next;
      end
   end

   // outputs decode registered state only, so a command in flight cannot glitch them
   assign band_sel_out = r_reg.cfg[fsc_pkg::BAND_HI:fsc_pkg::BAND_LO]; // RULE7
   assign load_cap_code_out = r_reg.cfg[fsc_pkg::LOAD_HI:fsc_pkg::LOAD_LO]; // RULE8
   assign clkout_div_code_out = r_reg.cfg[fsc_pkg::CLKDIV_HI:fsc_pkg::CLKDIV_LO];
   assign deviation_step_out = {1'b0, r_reg.cfg[fsc_pkg::DEV_HI:fsc_pkg::DEV_LO]} + 4'h1; // RULE10
   assign deviation_dir_out = r_reg.cfg[fsc_pkg::DEV_SIGN] ^ r_reg.fsk_s2; // RULE10

   assign osc_on_out = r_reg.pm[fsc_pkg::PM_OSC] || r_reg.hold
                       || (auto_osc && r_reg.seq != fsc_pkg::FSC_IDLE); // RULE15 RULE20
   assign synth_on_out = r_reg.pm[fsc_pkg::PM_SYNTH] || (auto_osc && (r_reg.seq == fsc_pkg::FSC_SYNTH_WAIT
                         || r_reg.seq == fsc_pkg::FSC_RUN)); // RULE15
   assign amp_on_out = r_reg.pm[fsc_pkg::PM_AMP] || (auto_osc && auto_amp
                       && r_reg.seq == fsc_pkg::FSC_RUN); // RULE16

   assign battery_detect_on_out = r_reg.pm[fsc_pkg::PM_BATT]; // RULE12
   assign wake_timer_on_out = r_reg.pm[fsc_pkg::PM_WAKE]; // RULE12
   assign clkout_en_out = osc_on_out && !r_reg.pm[fsc_pkg::PM_CLKDIS]; // RULE13
   assign clkout_out = r_reg.clk_q && clkout_en_out;
   assign por_busy_out = r_reg.por_busy;

   reset_defaults_a: assert property (@(posedge sys_clk_in) // RULE5
      srst_in |=> (r_reg.cfg == fsc_pkg::CFG_RESET && r_reg.pm == fsc_pkg::PM_RESET && r_reg.por_busy))
      else $error("registers not at defaults after reset");

   por_ignore_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE6
      r_reg.por_busy |=> ($stable(r_reg.cfg) && $stable(r_reg.pm) && !r_reg.applied))
      else $error("command taken during power-on timeout");

   por_release_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE6
      (r_reg.por_busy && r_reg.por_cnt == 24'(POR_LEN - 1)) |=> !r_reg.por_busy)
      else $error("power-on timeout did not end");

   cfg_apply_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE7
      (word_done && lnk.word[15:13] == fsc_pkg::CMD_CFG_CODE)
      |=> (band_sel_out == $past(lnk.word[12:11]) && load_cap_code_out == $past(lnk.word[7:4])))
      else $error("configuration command not applied");

   pm_apply_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE12
      (word_done && lnk.word[15:8] == fsc_pkg::CMD_PM_CODE)
      |=> (r_reg.pm == $past(lnk.word) && battery_detect_on_out == $past(lnk.word[fsc_pkg::PM_BATT])))
      else $error("power management command not applied");

   partial_drop_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE23
      r_reg.applied |-> ($past(lnk.count) == fsc_pkg::WORD_BITS && $past(lnk.byte_done)))
      else $error("command applied before full word");

   cut_word_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE23
      (lnk.byte_done && lnk.count != fsc_pkg::WORD_BITS) |=> ($stable(r_reg.cfg) && $stable(r_reg.pm)))
      else $error("short word changed a register");

   clk_div_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE9
      r_reg.div_cnt < 6'h32)
      else $error("host clock divider out of range");

   clk_disable_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE13
      r_reg.pm[fsc_pkg::PM_CLKDIS] |-> (!clkout_en_out && !clkout_out))
      else $error("clock output driven while disabled");

   tx_start_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE14
      (tx_hit && auto_osc && r_reg.seq == fsc_pkg::FSC_IDLE && !osc_on_out)
      |=> (r_reg.seq == fsc_pkg::FSC_OSC_WAIT))
      else $error("data transmit did not start the oscillator wait");

   synth_order_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE15
      (r_reg.seq == fsc_pkg::FSC_OSC_WAIT) |-> (osc_on_out && (synth_on_out == r_reg.pm[fsc_pkg::PM_SYNTH])))
      else $error("synthesizer started before oscillator stable");

   amp_lock_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE16
      (amp_on_out && !r_reg.pm[fsc_pkg::PM_AMP]) |-> (auto_amp && synth_on_out && $past(synth_on_out)))
      else $error("amplifier on without lock delay");

   sleep_stop_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE22
      (sleep_hit && !r_reg.pm[fsc_pkg::PM_AMP] && !r_reg.pm[fsc_pkg::PM_SYNTH]) |=> (!amp_on_out && !synth_on_out))
      else $error("sleep did not stop amplifier and synthesizer");

   sleep_tail_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE22
      (sleep_hit && r_reg.seq != fsc_pkg::FSC_IDLE && !r_reg.pm[fsc_pkg::PM_OSC])
      |=> (r_reg.seq == fsc_pkg::FSC_TAIL && r_reg.tail_left == $past(lnk.word[7:0])))
      else $error("sleep did not start the oscillator tail");

   tail_count_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE22
      (r_reg.seq == fsc_pkg::FSC_TAIL && r_reg.period_tick && r_reg.tail_left != 8'h00 && !sleep_hit)
      |=> (r_reg.tail_left == $past(r_reg.tail_left) - 8'h01))
      else $error("oscillator tail not counted in host clock periods");

   event_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE20
      (battery_event_in || wake_event_in) |=> (osc_on_out && r_reg.hold))
      else $error("event did not run the oscillator");

   sleep_event_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // RULE21
      (sleep_hit && !battery_event_in && !wake_event_in) |=> !r_reg.hold)
      else $error("sleep did not reset event controller");
endmodule

// ===== verif/fsc_host_model.sv
/*
   Host side of the serial command link: select, serial clock and data driven from a task.
   Assumes the caller gives the system clock; pins change only at its falling edge.
*/
`timescale 1ns/1ps
module fsc_host_model (
   input  wire logic sys_clk_in,
   output logic      select_low_out,
   output logic      serial_clk_out,
   output logic      serial_data_out
);
   initial begin
      select_low_out  = 1'h1;
      serial_clk_out  = 1'h0;
      serial_data_out = 1'h0;
   end

   task automatic wait_neg(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   // sends the top nbits of w; a count of 8 sends the one-byte data transmit command or cuts a word on purpose
   task automatic frame(input logic [15:0] w, input int nbits);
      int i;
      wait_neg(1);
      select_low_out = 1'h0;
      for (i = 15; i > 15 - nbits; i--) begin
         serial_data_out = w[i];
         wait_neg(4);
         serial_clk_out = 1'h1;
         wait_neg(4);
         serial_clk_out = 1'h0;
      end
      wait_neg(1);
      select_low_out  = 1'h1;
      // a released data line must not keep showing the last bit
      serial_data_out = ~serial_data_out;
      wait_neg(4);
   endtask
endmodule

// ===== verif/tb_fsc_cmd_top.sv
/*
   Self-checking bench of the serial command block, one task per scenario.
   Assumes shortened power-on, oscillator and PLL counts and a 10 MHz crystal host clock table.
*/
`timescale 1ns/1ps
module tb_fsc_cmd_top;
   localparam int POR_N = 200;
   localparam int OSC_N = 50;
   localparam int PLL_N = 20;
   logic       sys_clk_in;
   logic       srst_in;
   logic       fsk_data_in;
   logic       battery_event_in;
   logic       wake_event_in;
   logic       select_low;
   logic       serial_clk;
   logic       serial_data;
   logic [1:0] band_sel;
   logic [3:0] load_cap_code;
   logic [2:0] clkout_div_code;
   logic [3:0] deviation_step;
   logic       deviation_dir, osc_on, synth_on, amp_on, batt_on, wake_on;
   logic       clkout, clkout_en, por_busy;
   int         bad_count = 0;
   int         comparisons = 0;
   int         cycles = 0;
   int         per [8] = '{100, 80, 60, 50, 40, 30, 20, 10};

   fsc_cmd_top #(.POR_LEN(POR_N), .OSC_LEN(OSC_N), .PLL_LEN(PLL_N)) u_dut (
      .sys_clk_in            (sys_clk_in),
      .srst_in               (srst_in),
      .select_low_in         (select_low),
      .serial_clk_in         (serial_clk),
      .serial_data_in        (serial_data),
      .fsk_data_in           (fsk_data_in),
      .battery_event_in      (battery_event_in),
      .wake_event_in         (wake_event_in),
      .band_sel_out          (band_sel),
      .load_cap_code_out     (load_cap_code),
      .clkout_div_code_out   (clkout_div_code),
      .deviation_step_out    (deviation_step),
      .deviation_dir_out     (deviation_dir),
      .osc_on_out            (osc_on),
      .synth_on_out          (synth_on),
      .amp_on_out            (amp_on),
      .battery_detect_on_out (batt_on),
      .wake_timer_on_out     (wake_on),
      .clkout_out            (clkout),
      .clkout_en_out         (clkout_en),
      .por_busy_out          (por_busy)
   );

   fsc_host_model u_host (
      .sys_clk_in      (sys_clk_in),
      .select_low_out  (select_low),
      .serial_clk_out  (serial_clk),
      .serial_data_out (serial_data)
   );

   task automatic wrap_up();
      $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // bounded wait for a level; a miss shows up as a mismatch
   task automatic wait_lvl(ref logic s, input logic lvl, input int lim, output int n);
      n = 0;
      while (s !== lvl && n < lim) begin
         @(negedge sys_clk_in);
         n++;
      end
      chk(16'(s), 16'(lvl));
   endtask

   task automatic t_reset_por();
      int n;
      chk(16'({band_sel, load_cap_code, clkout_div_code}), 16'h0040);
      chk(16'(deviation_step), 16'h0001);
      chk(16'({osc_on, synth_on, amp_on, batt_on, wake_on}), 16'h0010);
      chk(16'({clkout_en, por_busy}), 16'h0003);
      u_host.frame(16'h9A55, 16);
      chk(16'(band_sel), 16'h0000);
      wait_lvl(por_busy, 1'h0, POR_N, n);
   endtask

   task automatic t_config();
      int i, a, b;
      logic [15:0] w;
      logic [1:0] bd;
      logic [2:0] dv;
      for (i = 0; i < 8; i++) begin
         bd = 2'(i % 3 + 1);
         dv = 3'(i % 7);
         w  = {3'h4, bd, 3'(i), 4'(2 * i + 1), i[0], dv};
         u_host.frame(w, 16);
         chk(16'(band_sel), 16'(bd));
         chk(16'(load_cap_code), 16'(2 * i + 1));
         chk(16'(clkout_div_code), 16'(i));
         chk(16'(deviation_step), 16'(dv) + 16'h0001);
         chk(16'(deviation_dir), 16'({i[0]}));
         fsk_data_in = 1'h1;
         repeat (4) @(negedge sys_clk_in);
         chk(16'(deviation_dir), 16'({~i[0]}));
         fsk_data_in = 1'h0;
         wait_lvl(clkout, 1'h0, 200, a);
         wait_lvl(clkout, 1'h1, 200, a);
         wait_lvl(clkout, 1'h0, 200, a);
         wait_lvl(clkout, 1'h1, 200, b);
         chk(16'(a + b), 16'(per[i]));
      end
   endtask

   task automatic t_cut_word();
      u_host.frame(16'h9FFF, 8);
      u_host.frame(16'h9FFF, 8);
      chk(16'(band_sel), 16'h0002);
      u_host.frame(16'h8A50, 16);
      chk(16'({band_sel, clkout_div_code, load_cap_code}), 16'h00A5);
   endtask

   task automatic t_pm_bits();
      int k;
      logic [15:0] w;
      u_host.frame(16'hC400, 16);
      for (k = 1; k < 6; k++) begin
         w = 16'hC000 | (16'h0001 << k);
         u_host.frame(w, 16);
         chk(16'({osc_on, synth_on, amp_on, batt_on, wake_on}), 16'(w[5:1]));
      end
      u_host.frame(16'hC021, 16);
      chk(16'({osc_on, clkout_en}), 16'h0002);
      u_host.frame(16'hC020, 16);
      chk(16'({osc_on, clkout_en}), 16'h0003);
   endtask

   task automatic t_auto();
      int n;
      u_host.frame(16'hC0C0, 16);
      chk(16'(osc_on), 16'h0000);
      u_host.frame(16'hC600, 8);
      wait_lvl(osc_on, 1'h1, 20, n);
      chk(16'(synth_on), 16'h0000);
      wait_lvl(synth_on, 1'h1, OSC_N + 20, n);
      chk(16'(n >= OSC_N - 15), 16'h0001);
      chk(16'(amp_on), 16'h0000);
      wait_lvl(amp_on, 1'h1, PLL_N + 20, n);
      chk(16'(n >= PLL_N - 5), 16'h0001);
      u_host.frame(16'hC405, 16);
      chk(16'({osc_on, synth_on, amp_on}), 16'h0004);
      wait_lvl(osc_on, 1'h0, 700, n);
      chk(16'(n >= 4 * per[2] - 20 && n <= 5 * per[2]), 16'h0001);
      u_host.frame(16'hC080, 16);
      u_host.frame(16'hC600, 8);
      wait_lvl(synth_on, 1'h1, OSC_N + 30, n);
      repeat (PLL_N + 10) @(negedge sys_clk_in);
      chk(16'(amp_on), 16'h0000);
      u_host.frame(16'hC400, 16);
      chk(16'({osc_on, synth_on}), 16'h0000);
   endtask

   task automatic t_events();
      battery_event_in = 1'h1;
      @(negedge sys_clk_in);
      battery_event_in = 1'h0;
      repeat (300) @(negedge sys_clk_in);
      chk(16'({osc_on, clkout_en}), 16'h0003);
      u_host.frame(16'hC400, 16);
      chk(16'(osc_on), 16'h0000);
      wake_event_in = 1'h1;
      @(negedge sys_clk_in);
      wake_event_in = 1'h0;
      repeat (2) @(negedge sys_clk_in);
      chk(16'(osc_on), 16'h0001);
      u_host.frame(16'hC081, 16);
      chk(16'({osc_on, clkout_en}), 16'h0000);
   endtask

   initial begin
      sys_clk_in = 1'h0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         wrap_up();
      end
   end

   initial begin
      srst_in          = 1'h1;
      fsk_data_in      = 1'h0;
      battery_event_in = 1'h0;
      wake_event_in    = 1'h0;
      repeat (2) @(negedge sys_clk_in);
      srst_in = 1'h0;
      t_reset_por();
      t_config();
      t_cut_word();
      t_pm_bits();
      t_auto();
      t_events();
      wrap_up();
   end
endmodule
